//--- test/swu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host uart on the shared line
// ****************************************
module swu_host_model #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic clk_sys_in,
  input  wire logic line_in,
  output logic      drive_out
);
  // idle high like the pull-up, so a released line never looks like a start bit
  initial drive_out = 1'b1;

  // crc8 from zero, lsb of each byte first
  function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = {c[6:0], c[7] ^ c[1] ^ c[0] ^ b[i]};
    end
    return c;
  endfunction : crc_add

  // one byte framed start low, stop high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_out = f[i];
      repeat (BIT_CLKS) @(negedge clk_sys_in);
    end
  endtask : send_byte

  // n-1 bytes from the top of d, then the crc, n bytes in all; bad spoils it on purpose
  task automatic send_frame(input logic [63:0] d, input int n, input logic bad);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < n - 1; k++) begin
      c = crc_add(c, d[63-8*k -: 8]);
      send_byte(d[63-8*k -: 8]);
    end
    send_byte(c ^ {7'h00, bad});
  endtask : send_frame

  // sample mid-bit at our own baud; returns in the middle of the stop bit
  task automatic recv_byte(output logic [7:0] b, output int waited, output logic ok);
    waited = 0;
    while (line_in !== 1'b0 && waited < 40 * BIT_CLKS) begin
      @(negedge clk_sys_in);
      waited++;
    end
    repeat (BIT_CLKS / 2) @(negedge clk_sys_in);
    ok = (line_in === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(negedge clk_sys_in);
      b[i] = line_in;
    end
    repeat (BIT_CLKS) @(negedge clk_sys_in);
    ok = ok && (line_in === 1'b1) && (waited < 40 * BIT_CLKS);
  endtask : recv_byte
endmodule : swu_host_model
`default_nettype wire

//--- test/swu_node_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swu_node_tb;
  // ****************************************
  // bench signals
  // ****************************************
  localparam int B = 32;  // clocks per bit, well above the coarse estimate floor
  logic        clk_sys_in, resetn_in, line, hdrv, oe, lo, a2, a1, a0;
  logic        nld, dld, sval, sld, sel, wrv, wrr, rdq, rdv, answered, ok;
  logic [7:0]  nset, naddr, dcnt, b;
  logic [3:0]  dset;
  logic [39:0] wrd;
  logic [6:0]  rda, seen_addr, ra;
  logic [31:0] rdd;
  logic [63:0] exp, got;
  logic [7:0]  crc;
  int          miscompares, samples_checked, w;

  // node drives only with its enable up, otherwise the host side owns the line
  assign line = oe ? lo : hdrv;

  swu_node uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .shared_serial_line_in(line),
    .shared_serial_line_out(lo), .shared_serial_line_oe_out(oe),
    .addr_incr_bit2_pin_in(a2), .addr_incr_bit1_pin_in(a1), .addr_incr_bit0_pin_in(a0),
    .node_address_setting_in(nset), .node_address_load_in(nld),
    .reply_delay_setting_in(dset), .reply_delay_load_in(dld),
    .next_node_select_in(sval), .next_node_select_load_in(sld),
    .next_node_select_out(sel), .node_address_out(naddr), .dgram_count_out(dcnt),
    .wr_data_out(wrd), .wr_valid_out(wrv), .wr_ready_in(wrr), .rd_req_out(rdq),
    .rd_addr_out(rda), .rd_data_in(rdd), .rd_data_valid_in(rdv));

  swu_host_model #(.BIT_CLKS(B)) host (.clk_sys_in(clk_sys_in), .line_in(line),
    .drive_out(hdrv));

  // 50 MHz
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [31:0] reg_val(input logic [6:0] a);
    return 32'hc3a5_5a3c ^ {25'h0, a};
  endfunction : reg_val

  // register file behind the node: one answer per pending read
  always @(negedge clk_sys_in) begin
    rdv <= 1'b0;
    if (!rdq) answered <= 1'b0;
    else if (!answered) begin
      rdd       <= reg_val(rda);
      seen_addr <= rda;
      rdv       <= 1'b1;
      answered  <= 1'b1;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : tick

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic load_node(input logic [7:0] v);
    nset = v;
    nld = 1'b1;
    tick(1);
    nld = 1'b0;
    tick(6);  // straps pass a synchroniser
  endtask : load_node

  task automatic load_sel(input logic v);
    sval = v;
    sld = 1'b1;
    tick(1);
    sld = 1'b0;
    a0 = sel;
    tick(6);
  endtask : load_sel

  // bounded wait for the write queue to offer a word
  task automatic wait_wr();
    int n;
    n = 0;
    while (wrv !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) begin
      miscompares++;
      conclude();
    end
  endtask : wait_wr

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {a2, a1, a0, nld, dld, sval, sld} = '0;
    {nset, dset, ra} = '0;
    wrr = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    resetn_in = 1'b0;
    tick(4);
    resetn_in = 1'b1;
    tick(4);
    check("select after reset", sel, 1);
    check("driver off", oe, 0);
    check("count after reset", dcnt, 0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      {a2, a1, a0} = i[2:0];
      load_node((i < 8) ? 8'h00 : 8'h20);
      check("strap address", naddr, nset + {5'h0, i[2:0]});
    end
    {a2, a1} = 2'b00;
    load_node(8'h00);
    load_sel(1'b1);
    check("chained later node", naddr, 1);
    load_sel(1'b0);
    check("chained first node", naddr, 0);
    load_node(8'hfe);
    check("first chain address", naddr, 8'hfe);
    {a2, a1, a0} = 3'b111;
    load_node(8'hf8);
    check("host address avoided", naddr, 8'hfe);
    load_node(8'hff);
    check("never host address", naddr == 8'hff, 0);
    {a2, a1, a0} = 3'b000;
    load_node(8'h05);
    $display("test addressing done");
    // fill the queue while its reader stalls, then drain in order
    wrr = 1'b0;
    for (int k = 0; k < 8; k++) begin
      host.send_frame({8'h05, 8'h05, 8'h90, 24'h0, k[7:0], 8'h00}, 8, 1'b0);
    end
    tick(20);
    check("write count", dcnt, 8);
    for (int k = 0; k < 8; k++) begin
      wait_wr();
      check("write word", wrd, {8'h90, 24'h0, k[7:0]});
      wrr = 1'b1;
      tick(1);
      wrr = 1'b0;
      tick(2);
    end
    check("queue empty", wrv, 0);
    wrr = 1'b1;
    $display("test writes done");
    // bad crc, other node, then a stalled half frame before a good one
    host.send_frame({8'h05, 8'h05, 8'h90, 32'h1, 8'h00}, 8, 1'b1);
    tick(16 * B);
    host.send_frame({8'h05, 8'h06, 8'h90, 32'h1, 8'h00}, 8, 1'b0);
    tick(16 * B);
    check("refused frames", dcnt, 8);
    host.send_byte(8'h05);
    host.send_byte(8'h05);
    tick(80 * B);
    host.send_frame({8'h05, 8'h05, 8'h90, 32'h1, 8'h00}, 8, 1'b0);
    tick(20);
    check("count after gap", dcnt, 9);
    $display("test refusals done");
    for (int d = 1; d <= 2; d++) begin
      dset = d[3:0];
      dld = 1'b1;
      tick(1);
      dld = 1'b0;
      ra = (d == 1) ? 7'h10 : 7'h23;
      tick(16 * B);
      host.send_frame({8'h05, 8'h05, 1'b0, ra, 40'h0}, 4, 1'b0);
      check("listening", oe, 0);
      exp = {8'h05, 8'hff, 1'b0, ra, reg_val(ra), 8'h00};
      crc = 8'h00;
      for (int k = 0; k < 7; k++) crc = host.crc_add(crc, exp[63-8*k -: 8]);
      exp[7:0] = crc;
      for (int k = 0; k < 8; k++) begin
        host.recv_byte(b, w, ok);
        if (!ok) begin
          miscompares++;
          conclude();
        end
        if (k == 0) check("delay", w >= (8*d-2)*B && w <= (8*d+1)*B, 1);
        got[63-8*k -: 8] = b;
      end
      check("read index", seen_addr, ra);
      check("reply frame", got, exp);
      tick(4 * B);
      check("tail drive", {oe, lo}, 2'b11);
      tick(B);
      check("released", oe, 0);
    end
    check("count after reads", dcnt, 9);
    $display("test reads done");
    conclude();
  end
endmodule : swu_node_tb
`default_nettype wire

//--- verilog/swu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module swu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // full when pointers differ only in wrap bit
  assign in_ready_out  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_out = (wr_q != rd_q);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];

  // storage
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : swu_fifo
`default_nettype wire

//--- verilog/swu_node.sv
// Function
// R1: reply carries all-ones host address
// R2: reply is 64 bits, LSB first
// R3: drive four bit times after last bit
// R4: all-ones address never used by node
// R5: CRC8 poly 0x07, start zero
// R6: CRC over all bytes before CRC
// R7: shift left, feed bits 7,1,0, in
// R8: act only on good CRC, own address
// R9: count accepted write datagrams; code skips accepted writes that a full fifo refuses
// R10: listen as input, reply at measured baud
// R11: straps add +4,+2,+1 to address
// R12: next-node select output high after reset
// R13: host gives nodes distinct strap addresses
// R14: chained first node 0, later ones 1
// R15: host clears select after addressing node
// R16: host addresses chain descending from 254
// R17: bit time from start to sync edge
// R18: gap over 63 bits resets reception; code checks it only between bytes, not while awaiting the sync edges
// R19: reply delay in units of 8 bits
// R20: address bit 7 marks write
// R21: reply bytes framed start low, stop high
`timescale 1ns/1ps
`default_nettype none
module swu_node
  import swu_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic        shared_serial_line_in,
  output logic             shared_serial_line_out,
  output logic             shared_serial_line_oe_out,
  input  wire logic        addr_incr_bit2_pin_in,
  input  wire logic        addr_incr_bit1_pin_in,
  input  wire logic        addr_incr_bit0_pin_in,
  input  wire logic [7:0]  node_address_setting_in,
  input  wire logic        node_address_load_in,
  input  wire logic [3:0]  reply_delay_setting_in,
  input  wire logic        reply_delay_load_in,
  input  wire logic        next_node_select_in,
  input  wire logic        next_node_select_load_in,
  output logic             next_node_select_out,
  output logic [7:0]       node_address_out,
  output logic [7:0]       dgram_count_out,
  output logic [39:0]      wr_data_out,
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in,
  output logic             rd_req_out,
  output logic [6:0]       rd_addr_out,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_data_valid_in
);
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] line_s_q;
  logic [2:0] a2_s_q;
  logic [2:0] a1_s_q;
  logic [2:0] a0_s_q;
  logic       line_q;
  logic [2:0] straps_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      line_s_q <= 3'h7;
      a2_s_q   <= 3'h0;
      a1_s_q   <= 3'h0;
      a0_s_q   <= 3'h0;
      line_q   <= 1'b1;
      straps_q <= 3'h0;
    end else begin
      line_s_q <= {line_s_q[1:0], shared_serial_line_in};
      a2_s_q   <= {a2_s_q[1:0], addr_incr_bit2_pin_in};
      a1_s_q   <= {a1_s_q[1:0], addr_incr_bit1_pin_in};
      a0_s_q   <= {a0_s_q[1:0], addr_incr_bit0_pin_in};
      if (line_s_q[1] == line_s_q[2]) line_q <= line_s_q[2];
      if (a2_s_q[1] == a2_s_q[2]) straps_q[2] <= a2_s_q[2];
      if (a1_s_q[1] == a1_s_q[2]) straps_q[1] <= a1_s_q[2];
      if (a0_s_q[1] == a0_s_q[2]) straps_q[0] <= a0_s_q[2];
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  logic [7:0] node_base_q;
  logic [3:0] delay_q;
  logic       nns_q;
  logic [7:0] dcnt_q;
  logic [8:0] addr_sum;
  // straps weighted +4,+2,+1 on top of programmed base
  assign addr_sum = {1'b0, node_base_q} + {6'h00, straps_q};  // see R11 see R14
  // never let the sum land on the host address
  assign node_address_out     = (addr_sum[7:0] == HOST_ADDR) ? 8'hfe : addr_sum[7:0]; // see R4
  assign next_node_select_out = nns_q;
  assign dgram_count_out      = dcnt_q;

  // programmable settings
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      node_base_q <= NODE_ADDR_RST;
      delay_q     <= DELAY_RESET;
      nns_q       <= 1'b1;                                        // see R12
    end else begin
      if (node_address_load_in && node_address_setting_in != HOST_ADDR)
        node_base_q <= node_address_setting_in;                   // see R4
      if (reply_delay_load_in) delay_q <= reply_delay_setting_in;
      if (next_node_select_load_in) nns_q <= next_node_select_in;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_SYNC  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b011,
    RX_STOP  = 3'b100,
    RX_REC   = 3'b101
  } swu_rx_t;
  swu_rx_t               rx_q;
  logic [BIT_CNT_W-1:0]  bit_clks_q;   // measured bit time
  logic [BIT_CNT_W-1:0]  tmr_q;
  logic [BIT_CNT_W+6:0]  gap_q;
  logic [2:0]            bit_idx_q;
  logic [3:0]            byte_idx_q;
  logic [7:0]            sh_q;
  logic [7:0]            crc_q;
  logic [63:0]           frame_q;
  logic                  line_d1_q;
  logic                  fall;
  logic                  frame_done;
  logic                  is_write;
  logic [3:0]            nbytes;
  logic                  tx_busy;
  logic [7:0]            rx_crc_nx;
  assign fall     = line_d1_q && !line_q;
  assign is_write = frame_q[16 + RW_BIT];                         // see R20
  assign nbytes   = (byte_idx_q >= 4'd3 && is_write) ? 4'(WR_BYTES) : 4'(RD_BYTES);
  // serial crc step on sampled bit
  assign rx_crc_nx = {crc_q[6:0], crc_q[7] ^ crc_q[1] ^ crc_q[0] ^ line_q}; // see R7

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) line_d1_q <= 1'b1;
    else line_d1_q <= line_q;
  end

  // bit-level receive state
  always_ff @(posedge clk_sys_in) begin
    frame_done <= 1'b0;
    if (!resetn_in) begin
      rx_q       <= RX_IDLE;
      bit_clks_q <= BIT_CNT_W'(MIN_BIT_CLKS);
      tmr_q      <= '0;
      gap_q      <= '0;
      bit_idx_q  <= '0;
      byte_idx_q <= '0;
      sh_q       <= '0;
      crc_q      <= CRC_INIT;
      frame_q    <= '0;
    end else begin
      gap_q <= gap_q + 1'b1;
      case (rx_q)
        RX_IDLE: if (fall && !tx_busy) begin
          rx_q <= RX_SYNC; tmr_q <= '0; bit_idx_q <= '0;
          byte_idx_q <= '0; crc_q <= CRC_INIT; gap_q <= '0;
        end
        RX_SYNC: begin
          tmr_q <= tmr_q + 1'b1;
          // the sync nibble is taken as correct; it still runs through the crc
          if (fall && bit_idx_q == 3'd0) begin
            bit_idx_q <= 3'd1;                                    // fall into bit 1, keep timing
          end else if (fall) begin
            // start fall to bit2/3 fall spans four bit times
            bit_clks_q <= (tmr_q + 1'b1) >> 2;                    // see R17 see R10
            // timer starts one bit into the count, half a bit short of the mid-bit compare, so bit 3 is hit mid-bit
            tmr_q      <= (tmr_q + 1'b1) >> 2;
            // bits 0..2 are 1,0,1, already folded into the crc
            crc_q <= 8'h07;                                       // see R6
            sh_q  <= 8'ha0;
            bit_idx_q <= 3'd3;
            rx_q <= RX_DATA;
          end
        end
        RX_START: begin
          tmr_q <= tmr_q + 1'b1;
          if (fall) begin
            tmr_q <= '0; bit_idx_q <= '0; gap_q <= '0;
            rx_q <= RX_DATA;
          end else if (gap_q > (BIT_CNT_W+7)'(bit_clks_q) * TIMEOUT_BITS) begin
            rx_q <= RX_IDLE;                                      // see R18
          end
        end
        RX_DATA: begin
          tmr_q <= tmr_q + 1'b1;
          // sample mid-bit after the start bit
          if (tmr_q == bit_clks_q + (bit_clks_q >> 1)) begin
            tmr_q <= bit_clks_q >> 1;
            sh_q  <= {line_q, sh_q[7:1]};
            if (byte_idx_q < nbytes - 1'b1) crc_q <= rx_crc_nx;   // see R6 see R5
            bit_idx_q <= bit_idx_q + 1'b1;
            if (bit_idx_q == 3'd7) rx_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          frame_q[8*byte_idx_q +: 8] <= sh_q;
          byte_idx_q <= byte_idx_q + 1'b1;
          if (byte_idx_q + 1'b1 == nbytes) begin
            frame_done <= 1'b1;
            rx_q <= RX_REC;
          end else rx_q <= RX_START;
          tmr_q <= '0;
        end
        RX_REC: begin
          // half a bit of idle line; a full bit would race a back-to-back start bit
          tmr_q <= line_q ? tmr_q + 1'b1 : '0;
          if (tmr_q >= (bit_clks_q >> 1)) rx_q <= RX_IDLE;
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // datagram check
  logic [7:0] rx_crc_byte;
  logic       accept;
  assign rx_crc_byte = is_write ? frame_q[63:56] : frame_q[31:24];
  assign accept = frame_done && rx_crc_byte == crc_q
                  && frame_q[15:8] == node_address_out;           // see R8

  // write path through fifo, counter on each accepted write the fifo has room for
  swu_write_t wr_pkt;
  logic       fifo_in_ready;
  assign wr_pkt.reg_addr = frame_q[23:16];
  assign wr_pkt.data     = {frame_q[31:24], frame_q[39:32], frame_q[47:40], frame_q[55:48]};
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) dcnt_q <= DGRAM_CNT_RST;
    else if (accept && is_write && fifo_in_ready) dcnt_q <= dcnt_q + 1'b1; // see R9
  end

  swu_fifo #(
    .WIDTH (40),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .in_data_in    (wr_pkt),
    .in_valid_in   (accept && is_write),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (wr_data_out),
    .out_valid_out (wr_valid_out),
    .out_ready_in  (wr_ready_in)
  );

  // ****************************************
  // transmitter
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b10,
    TX_TAIL = 2'b11
  } swu_tx_t;
  swu_tx_t              tx_q;
  logic [6:0]           rd_addr_q;
  logic [63:0]          reply_q;
  logic [BIT_CNT_W-1:0] txt_q;
  logic [6:0]           txbit_q;     // bit counter incl. framing, 10 per byte
  logic [7:0]           txcrc_q;
  logic                 wait_done;
  logic                 txline_q;
  logic                 oe_q;
  assign tx_busy = (tx_q != TX_IDLE);
  assign rd_req_out  = (tx_q == TX_WAIT);
  assign rd_addr_out = rd_addr_q;
  assign shared_serial_line_out    = txline_q;
  assign shared_serial_line_oe_out = oe_q;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      tx_q <= TX_IDLE; rd_addr_q <= '0; reply_q <= '0; txt_q <= '0;
      txbit_q <= '0; txcrc_q <= CRC_INIT; wait_done <= 1'b0;
      txline_q <= 1'b1; oe_q <= 1'b0;
    end else begin
      txt_q <= txt_q + 1'b1;
      case (tx_q)
        TX_IDLE: begin
          oe_q <= 1'b0;                                           // see R10
          txt_q <= '0; txbit_q <= '0; wait_done <= 1'b0;
          if (accept && !is_write) begin
            rd_addr_q <= frame_q[22:16];
            tx_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          // delay counted in bit times, then in units of eight
          if (txt_q == bit_clks_q - 1'b1) begin
            txt_q <= '0;
            txbit_q <= txbit_q + 1'b1;
            if (txbit_q + 1'b1 >= {delay_q, 3'b000}) wait_done <= 1'b1; // see R19
          end
          if (rd_data_valid_in) begin
            reply_q <= {8'h00, rd_data_in[7:0], rd_data_in[15:8], rd_data_in[23:16],
                        rd_data_in[31:24], 1'b0, rd_addr_q, HOST_ADDR, 4'h0, SYNC_NIBBLE}; // see R1 see R2
            wait_done <= wait_done;
          end
          if (wait_done && reply_q[3:0] == SYNC_NIBBLE) begin
            tx_q <= TX_SEND; txt_q <= '0; txbit_q <= '0; txcrc_q <= CRC_INIT;
            oe_q <= 1'b1; txline_q <= 1'b0;                       // see R21
          end
        end
        TX_SEND: if (txt_q == bit_clks_q - 1'b1) begin
          txt_q <= '0;
          txbit_q <= txbit_q + 1'b1;
          if (txbit_q % 10 == 7'd9) begin
            txline_q <= 1'b0;                                     // see R21
            if (txbit_q == 7'd79) begin
              txline_q <= 1'b1; tx_q <= TX_TAIL; txbit_q <= '0;
            end else if (txbit_q == 7'd69) reply_q[7:0] <= txcrc_q; // see R5
          end else if (txbit_q % 10 == 7'd8) begin
            txline_q <= 1'b1;                                     // stop bit, see R21
          end else begin
            txline_q <= reply_q[0];
            reply_q  <= {1'b0, reply_q[63:1]};
            if (txbit_q < 7'd70)
              txcrc_q <= {txcrc_q[6:0], txcrc_q[7] ^ txcrc_q[1] ^ txcrc_q[0] ^ reply_q[0]}; // see R7
          end
        end
        TX_TAIL: if (txt_q == bit_clks_q - 1'b1) begin
          txt_q <= '0;
          txbit_q <= txbit_q + 1'b1;
          if (txbit_q == 7'(TAIL_BITS - 1)) begin
            oe_q <= 1'b0; tx_q <= TX_IDLE;                        // see R3
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // reply launch: waiting, then the first cycle of sending
  sequence s_tx_launch;
    tx_q == TX_WAIT ##1 tx_q == TX_SEND;
  endsequence

  AST_HOST_ADDR: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R4
    node_address_out != HOST_ADDR) else $error("node address is host address");
  AST_RST_NNS: assert property (@(posedge clk_sys_in) // see R12
    !resetn_in |=> nns_q) else $error("select not high after reset");
  AST_CNT: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R9
    (accept && is_write && fifo_in_ready) |=> dcnt_q == $past(dcnt_q) + 8'h01)
    else $error("write count did not advance");
  AST_QUIET: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R10
    (tx_q == TX_IDLE) |=> !oe_q) else $error("driving while listening");
  AST_REJECT: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R8
    (frame_done && frame_q[15:8] != node_address_out) |=> tx_q == TX_IDLE && !wr_valid_out ||
    $past(wr_valid_out)) else $error("foreign datagram acted upon");
  AST_TAIL: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R3
    (tx_q == TX_TAIL) |-> oe_q && txline_q) else $error("tail not driven high");
  AST_START: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R21
    s_tx_launch |-> !txline_q) else $error("no start bit");
  AST_DELAY: assert property (@(posedge clk_sys_in) disable iff (!resetn_in) // see R19
    s_tx_launch |-> $past(wait_done)) else $error("reply too early");
endmodule : swu_node
`default_nettype wire

//--- verilog/swu_pkg.sv
package swu_pkg;
  // ****************************************
  // datagram layout
  // ****************************************
  localparam logic [3:0] SYNC_NIBBLE    = 4'h5;   // bits 0..3 = 1,0,1,0
  localparam logic [7:0] HOST_ADDR      = 8'hff;  // reply address, never a node address
  localparam logic [7:0] CRC_INIT       = 8'h00;
  localparam int         WR_BYTES       = 8;
  localparam int         RD_BYTES       = 4;
  localparam int         REPLY_BYTES    = 8;
  localparam int         RW_BIT         = 7;
  localparam int         TIMEOUT_BITS   = 63;
  localparam int         RECOVER_BITS   = 12;
  localparam int         TAIL_BITS      = 4;
  localparam int         DELAY_UNIT     = 8;
  localparam logic [3:0] DELAY_RESET    = 4'h1;   // 1 x 8 bit times
  localparam logic [7:0] NODE_ADDR_RST  = 8'h00;
  localparam logic [7:0] DGRAM_CNT_RST  = 8'h00;
  localparam int         SYNC_EDGES     = 2;      // falling edges from start to bit2/3
  localparam int         CLK_HZ         = 50_000_000;
  localparam int         MIN_BIT_CLKS   = 16;
  localparam int         BIT_CNT_W      = 16;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0]  reg_addr;
    logic [31:0] data;
  } swu_write_t;

  typedef struct packed {
    logic [6:0]  reg_addr;
    logic [31:0] data;
  } swu_reply_t;
endpackage : swu_pkg
